// >>> tcco_pkg.sv
package tcco_pkg;

  // Data and address widths of the register port
  localparam int DW = 16;
  localparam int AW = 4;

  // Register word addresses
  localparam logic [AW-1:0] A_CTL   = 4'h0;
  localparam logic [AW-1:0] A_CNT   = 4'h1;
  localparam logic [AW-1:0] A_CCTL0 = 4'h2;
  localparam logic [AW-1:0] A_CCR0  = 4'h5;

  // Timer control register field positions
  localparam int CTL_OVF  = 0;
  localparam int CTL_CLR  = 2;
  localparam int CTL_MODE = 4;
  localparam int CTL_DIV  = 6;

  // Reset values and the zero and one constants
  localparam logic [DW-1:0] CNT_RST = 16'h0000;
  localparam logic [DW-1:0] CCR_RST = 16'h0000;
  localparam logic [DW-1:0] ZERO    = 16'h0000;
  localparam logic [DW-1:0] ONE     = 16'h0001;
  localparam logic [2:0]    DIV_RST = 3'h0;

  // Count mode selector codes
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_UP   = 2'b01,
    MODE_CONT = 2'b10,
    MODE_UPDN = 2'b11
  } tcco_mode_t;

  // Count direction state
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DN = 1'b1
  } tcco_dir_t;

  // Output unit modes
  typedef enum logic [2:0] {
    OM_OUT    = 3'b000,
    OM_SET    = 3'b001,
    OM_TGLRST = 3'b010,
    OM_SETRST = 3'b011,
    OM_TGL    = 3'b100,
    OM_RST    = 3'b101,
    OM_TGLSET = 3'b110,
    OM_RSTSET = 3'b111
  } tcco_outmode_t;

  // Capture edge selector codes
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } tcco_edge_t;

  // Channel control word layout, msb first
  typedef struct packed {
    tcco_edge_t    edge_sel;
    logic [1:0]    in_sel;
    logic          sync_cap;
    logic          latched_input_level;
    logic          rsv_hi;
    logic          cap_mode;
    tcco_outmode_t out_mode;
    logic          rsv_lo;
    logic          input_level_bit;
    logic          sw_out;
    logic          cov;
    logic          flag;
  } tcco_cctl_t;

endpackage

// >>> tcco_timer.sv
`timescale 1ns/10ps
module tcco_timer
  import tcco_pkg::*;
#(
  parameter int NCH = 3
) (
  input  wire logic           clk,      // 200 MHz clock
  input  wire logic           reset_n,  // Async reset, active low
  input  wire logic [AW-1:0]  addr,     // Register word address
  input  wire logic [DW-1:0]  wdata,    // Write data
  input  wire logic           wr,       // Write strobe
  input  wire logic           rd,       // Read strobe
  output logic      [DW-1:0]  rdata,    // Read data, next cycle
  input  wire logic [NCH-1:0] cap_a,    // Capture inputs a, pins
  input  wire logic [NCH-1:0] cap_b,    // Capture inputs b, pins
  output logic      [NCH-1:0] ch_out,   // Channel outputs
  output logic      [NCH-1:0] eq_pulse  // Equality pulses
);

  // Elaboration check on channel count
  if (NCH < 1 || NCH > 3) begin : g_chk
    $error("NCH must be 1 to 3");
  end

  // Control state
  tcco_mode_t       mode_r;
  logic [1:0]       div_sel_r;
  logic [2:0]       div_r;
  tcco_dir_t        dir_r;
  logic [DW-1:0]    cnt_r;
  logic             cnt_evt_r;
  logic             ovf_r;
  logic [DW-1:0]    rdata_r;
  logic [DW-1:0]    ccr_r [NCH];
  tcco_cctl_t       cctl_r [NCH];
  logic [NCH-1:0]   flag_r;
  logic [NCH-1:0]   cov_r;
  logic [NCH-1:0]   latched_input_level_r;
  logic [NCH-1:0]   out_r;
  logic [NCH-1:0]   lvl_w;
  logic [NCH-1:0]   cap_evt_w;
  logic [NCH-1:0]   eq_w;

  // Decode helpers
  logic             wr_ctl;
  logic             wr_cnt;
  logic             clr_w;
  logic             tick_w;
  logic [2:0]       div_mask;
  logic             ovf_set;
  logic [DW-1:0]    ccr0;
  tcco_cctl_t       wcctl_w;

  assign wr_ctl   = wr && (addr == A_CTL);
  assign wr_cnt   = wr && (addr == A_CNT);
  assign clr_w    = wr_ctl && wdata[CTL_CLR];
  assign ccr0     = ccr_r[0];
  assign wcctl_w  = tcco_cctl_t'(wdata);
  assign div_mask = 3'((4'h1 << div_sel_r) - 4'h1);

  // Timer clock enable from the divider
  assign tick_w = (mode_r != MODE_STOP) && ((div_r & div_mask) == div_mask);

  // Overflow event when the down count reaches zero
  assign ovf_set = tick_w && (mode_r == MODE_UPDN) && (dir_r == DIR_DN)
                   && (cnt_r == ONE) && !clr_w && !wr_cnt;

  // Timer control fields
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r    <= MODE_STOP;
      div_sel_r <= 2'b00;
    end else if (wr_ctl) begin
      mode_r    <= tcco_mode_t'(wdata[CTL_MODE +: 2]);
      div_sel_r <= wdata[CTL_DIV +: 2];
    end
  end

  // Clock divider, cleared by the clear bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= DIV_RST;
    end else if (clr_w) begin
      div_r <= DIV_RST;
    end else if (mode_r != MODE_STOP) begin
      div_r <= div_r + 3'h1;
    end
  end

  // Overflow flag, a hardware set beats a software clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_r <= 1'b1;
    end else if (wr_ctl) begin
      ovf_r <= wdata[CTL_OVF];
    end
  end

  // Up/down counter with latched direction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= CNT_RST;
      dir_r <= DIR_UP;
    end else if (clr_w) begin
      cnt_r <= CNT_RST;
      dir_r <= DIR_UP;
    end else if (wr_cnt) begin
      cnt_r <= wdata;
    end else if (tick_w && mode_r == MODE_UPDN) begin
      case (dir_r)
        DIR_UP: begin
          if (ccr0 == ZERO) begin
            cnt_r <= cnt_r;
          end else if (cnt_r >= ccr0) begin
            dir_r <= DIR_DN;
            cnt_r <= cnt_r - ONE;
          end else begin
            cnt_r <= cnt_r + ONE;
          end
        end
        DIR_DN: begin
          if (cnt_r == ZERO) begin
            dir_r <= DIR_UP;
            cnt_r <= (ccr0 == ZERO) ? ZERO : ONE;
          end else begin
            cnt_r <= cnt_r - ONE;
          end
        end
        default: begin
          dir_r <= DIR_UP;
        end
      endcase
    end
  end

  // Marks a count that came from counting, not from a write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_evt_r <= 1'b0;
    end else begin
      cnt_evt_r <= tick_w && (mode_r == MODE_UPDN) && !clr_w
                   && !wr_cnt && (ccr0 != ZERO);
    end
  end

  // Per-channel capture/compare logic
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [1:0] a_sync_r;
    logic [1:0] b_sync_r;
    logic       prev_r;
    logic       pend_r;
    logic       rdok_r;
    logic       edge_w;
    logic       wr_cctl;
    logic       wr_ccr;
    logic       rd_ccr;

    assign wr_cctl = wr && (addr == 4'(A_CCTL0 + i));
    assign wr_ccr  = wr && (addr == 4'(A_CCR0 + i));
    assign rd_ccr  = rd && (addr == 4'(A_CCR0 + i));

    // Two-flop synchronisers on the capture pins
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        a_sync_r <= 2'b00;
        b_sync_r <= 2'b00;
      end else begin
        a_sync_r <= {a_sync_r[0], cap_a[i]};
        b_sync_r <= {b_sync_r[0], cap_b[i]};
      end
    end

    // Input selection, upper selector bit gives fixed levels
    always_comb begin
      if (cctl_r[i].in_sel[1]) begin
        lvl_w[i] = cctl_r[i].in_sel[0];
      end else if (cctl_r[i].in_sel[0]) begin
        lvl_w[i] = b_sync_r[1];
      end else begin
        lvl_w[i] = a_sync_r[1];
      end
    end

    // Previous sample for edge detection
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        prev_r <= 1'b0;
      end else begin
        prev_r <= lvl_w[i];
      end
    end

    // Selected edge of the chosen input
    always_comb begin
      case (cctl_r[i].edge_sel)
        EDGE_RISE: edge_w = lvl_w[i] && !prev_r;
        EDGE_FALL: edge_w = !lvl_w[i] && prev_r;
        EDGE_BOTH: edge_w = lvl_w[i] != prev_r;
        default:   edge_w = 1'b0;
      endcase
    end

    // Edge held until the next timer tick when sync is on
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        pend_r <= 1'b0;
      end else if (!cctl_r[i].cap_mode || !cctl_r[i].sync_cap) begin
        pend_r <= 1'b0;
      end else if (tick_w) begin
        pend_r <= 1'b0;
      end else if (edge_w) begin
        pend_r <= 1'b1;
      end
    end

    assign cap_evt_w[i] = cctl_r[i].cap_mode &&
      (cctl_r[i].sync_cap ? (tick_w && (pend_r || edge_w)) : edge_w);

    // Compare match only from counting, not gated by the channel mode
    assign eq_w[i] = cnt_evt_r && (cnt_r == ccr_r[i]);

    // Compare value: software write or capture, no buffering
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        ccr_r[i] <= CCR_RST;
      end else if (cap_evt_w[i]) begin
        ccr_r[i] <= cnt_r;
      end else if (wr_ccr) begin
        ccr_r[i] <= wdata;
      end
    end

    // Software control fields of the channel
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cctl_r[i] <= '0;
      end else if (wr_cctl) begin
        cctl_r[i] <= tcco_cctl_t'(wdata);
      end
    end

    // Channel flag, hardware set wins over software clear
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        flag_r[i] <= 1'b0;
      end else if (cap_evt_w[i]) begin
        flag_r[i] <= 1'b1;
      end else if (eq_w[i] && !cctl_r[i].cap_mode) begin
        flag_r[i] <= 1'b1;
      end else if (wr_cctl) begin
        flag_r[i] <= wcctl_w.flag;
      end
    end

    // Tracks whether the captured value has been read
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        rdok_r <= 1'b1;
      end else if (cap_evt_w[i]) begin
        rdok_r <= 1'b0;
      end else if (rd_ccr) begin
        rdok_r <= 1'b1;
      end
    end

    // Capture overflow, cleared only by a software write
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cov_r[i] <= 1'b0;
      end else if (cap_evt_w[i] && !rdok_r) begin
        cov_r[i] <= 1'b1;
      end else if (wr_cctl) begin
        cov_r[i] <= wcctl_w.cov;
      end
    end

    // Input level latched at a compare match
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        latched_input_level_r[i] <= 1'b0;
      end else if (eq_w[i] && !cctl_r[i].cap_mode) begin
        latched_input_level_r[i] <= lvl_w[i];
      end
    end

    // Output unit, updated on compare matches
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        out_r[i] <= 1'b0;
      end else if (clr_w) begin
        out_r[i] <= 1'b0;
      end else if (!cctl_r[i].cap_mode) begin
        case (cctl_r[i].out_mode)
          OM_SET: begin
            if (eq_w[i]) out_r[i] <= 1'b1;
          end
          OM_TGLRST: begin
            if (eq_w[0]) out_r[i] <= 1'b0;
            else if (eq_w[i]) out_r[i] <= !out_r[i];
          end
          OM_SETRST: begin
            if (eq_w[0]) out_r[i] <= 1'b0;
            else if (eq_w[i]) out_r[i] <= 1'b1;
          end
          OM_TGL: begin
            if (eq_w[i]) out_r[i] <= !out_r[i];
          end
          OM_RST: begin
            if (eq_w[i]) out_r[i] <= 1'b0;
          end
          OM_TGLSET: begin
            if (eq_w[0]) out_r[i] <= 1'b1;
            else if (eq_w[i]) out_r[i] <= !out_r[i];
          end
          OM_RSTSET: begin
            if (eq_w[0]) out_r[i] <= 1'b1;
            else if (eq_w[i]) out_r[i] <= 1'b0;
          end
          default: begin
            out_r[i] <= cctl_r[i].sw_out;
          end
        endcase
      end
    end

    // Mode 0 follows the software bit at once
    assign ch_out[i] = (!cctl_r[i].cap_mode &&
                        cctl_r[i].out_mode == OM_OUT) ?
                       cctl_r[i].sw_out : out_r[i];
    assign eq_pulse[i] = eq_w[i] && !cctl_r[i].cap_mode;
  end

  // Read multiplexer, data registered for the next cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= ZERO;
    end else if (rd) begin
      rdata_r <= ZERO;
      if (addr == A_CTL) begin
        rdata_r[CTL_OVF]       <= ovf_r;
        rdata_r[CTL_MODE +: 2] <= mode_r;
        rdata_r[CTL_DIV +: 2]  <= div_sel_r;
      end else if (addr == A_CNT) begin
        rdata_r <= cnt_r;
      end
      for (int k = 0; k < NCH; k++) begin
        if (addr == 4'(A_CCTL0 + k)) begin
          rdata_r <= {cctl_r[k].edge_sel, cctl_r[k].in_sel,
                      cctl_r[k].sync_cap, latched_input_level_r[k], 1'b0,
                      cctl_r[k].cap_mode, cctl_r[k].out_mode, 1'b0,
                      lvl_w[k], cctl_r[k].sw_out, cov_r[k],
                      flag_r[k]};
        end
        if (addr == 4'(A_CCR0 + k)) begin
          rdata_r <= ccr_r[k];
        end
      end
    end else begin
      rdata_r <= ZERO;
    end
  end

  assign rdata = rdata_r;

endmodule

// >>> tcco_timer_properties.sv
`timescale 1ns/10ps
module tcco_timer_properties
  import tcco_pkg::*;
#(
  parameter int NCH = 3
) (
  input wire logic           clk,      // Clock
  input wire logic           reset_n,  // Reset
  input wire logic [AW-1:0]  addr,     // Address
  input wire logic [DW-1:0]  wdata,    // Write data
  input wire logic           wr,       // Write strobe
  input wire logic           rd,       // Read strobe
  input wire logic [DW-1:0]  rdata,    // Read data
  input wire logic [NCH-1:0] cap_a,    // Pins a
  input wire logic [NCH-1:0] cap_b,    // Pins b
  input wire logic [NCH-1:0] ch_out,   // Outputs
  input wire logic [NCH-1:0] eq_pulse  // Matches
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic [1:0]    mode_r;
  logic [1:0]    div_r;
  logic [1:0]    sel2_r;
  logic [DW-1:0] ccr0_r;
  logic [DW:0]   gap_r;
  logic          stab_r;

  // Shadow of the setup written by software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= 2'h0;
      div_r  <= 2'h0;
      sel2_r <= 2'h0;
      ccr0_r <= CCR_RST;
    end else if (wr) begin
      if (addr == A_CTL) begin
        mode_r <= wdata[CTL_MODE+:2];
        div_r  <= wdata[CTL_DIV+:2];
      end
      if (addr == A_CCTL0 + 4'h2) begin
        sel2_r <= wdata[13:12];
      end
      if (addr == A_CCR0) begin
        ccr0_r <= wdata;
      end
    end
  end

  // Cycles since the last period match; any write makes it stale
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_r  <= '0;
      stab_r <= 1'b0;
    end else begin
      gap_r  <= eq_pulse[0] ? 17'h00001 : gap_r + 17'h00001;
      stab_r <= !wr && (eq_pulse[0] || stab_r);
    end
  end

  // Count written while stopped, then read back
  sequence s_cnt_wr_rd;
    (wr && addr == A_CNT && mode_r == MODE_STOP) ##1 !wr
      ##1 (rd && addr == A_CNT);
  endsequence

  // Pin quiet, then level bit of channel 2 read
  sequence s_pin_quiet;
    $stable(cap_a[2]) [*4] ##0
      (rd && addr == A_CCTL0 + 4'h2 && sel2_r == 2'h0);
  endsequence

  AST_CNT_HOLD:
  assert property (s_cnt_wr_rd |=> rdata == $past(wdata, 3))
    else $error("count lost its written value");
  AST_LEVEL_BIT:
  assert property (s_pin_quiet |=> rdata[3] == $past(cap_a[2]))
    else $error("input level bit wrong");
  AST_STOP_QUIET:
  assert property ((mode_r != MODE_UPDN) [*3] |-> eq_pulse == '0)
    else $error("match pulse while not counting");
  AST_PERIOD_SPAN:
  assert property (eq_pulse[0] && stab_r && div_r == 2'h0
                   |-> gap_r == {ccr0_r, 1'b0})
    else $error("period match spacing wrong");
  AST_SW_OUT_NOW:
  assert property (wr && addr == A_CCTL0 + 4'h1 && wdata[8:5] == 4'h0
                   |=> ch_out[1] == $past(wdata[2]))
    else $error("mode 0 output not the software bit");
  AST_EQ_ONE:
  assert property (eq_pulse[1] |=> !eq_pulse[1])
    else $error("match pulse longer than one cycle");
  AST_CLR_READ:
  assert property (rd && addr == A_CTL |=> !rdata[CTL_CLR])
    else $error("clear bit read back as 1");
  AST_UNMAPPED:
  assert property (rd && addr > A_CCR0 + 4'h2 |=> rdata == '0)
    else $error("unmapped read not zero");
endmodule

bind tcco_timer tcco_timer_properties #(.NCH(NCH)) u_props (
  .clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
  .cap_a, .cap_b, .ch_out, .eq_pulse
);

// >>> tcco_pin_model.sv
`timescale 1ns/10ps
module tcco_pin_model (
  input  wire logic       clk,    // Timer clock
  output logic      [2:0] cap_a,  // Capture pins a
  output logic      [2:0] cap_b   // Capture pins b
);
  // Pins idle low
  initial begin
    cap_a = 3'h0;
    cap_b = 3'h0;
  end

  // Move one pin just after a rising edge
  task automatic drive(input int ch, input logic b, input logic lvl);
    @(posedge clk);
    if (b) begin
      cap_b[ch] <= lvl;
    end else begin
      cap_a[ch] <= lvl;
    end
  endtask
endmodule

// >>> tcco_timer_tb_top.sv
`timescale 1ns/10ps
module tcco_timer_tb_top import tcco_pkg::*;;
  logic          clk;
  logic          reset_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr;
  logic          rd;
  logic [DW-1:0] rdata;
  logic [2:0]    cap_a;
  logic [2:0]    cap_b;
  logic [2:0]    ch_out;
  logic [2:0]    eq_pulse;
  int            mismatches;
  int            check_count;

  tcco_timer #(.NCH(3)) DUT (
    .clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
    .cap_a, .cap_b, .ch_out, .eq_pulse
  );
  tcco_pin_model pins (.clk, .cap_a, .cap_b);

  // 200 MHz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [DW-1:0] e,
                     input logic [DW-1:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Bus tasks start just after a rising edge and end on one
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] v);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string n, input logic [AW-1:0] a,
                        input logic [DW-1:0] m, input logic [DW-1:0] e);
    logic [DW-1:0] v;
    rd_reg(a, v);
    chk(n, e, v & m);
  endtask

  // Wait for a match pulse, then one edge more so outputs settle
  task automatic wait_eq(input int ch);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (eq_pulse[ch] !== 1'b1 && i < 200);
    if (i >= 200) begin
      chk("match wait", 16'h0001, 16'h0000);
      print_verdict();
    end
    @(negedge clk);
  endtask

  task automatic sc_regs();
    rd_chk("ctl", A_CTL, 16'hffff, 16'h0000);  // Reset
    rd_chk("unmapped", 4'h9, 16'hffff, 16'h0000);
    wr_reg(A_CNT, 16'h1234);
    rd_chk("count", A_CNT, 16'hffff, 16'h1234);  // No event
    wr_reg(A_CCR0 + 4'h1, 16'h00a5);
    rd_chk("ccr1", A_CCR0 + 4'h1, 16'hffff, 16'h00a5);  // Direct
    rd_chk("flag0", A_CCTL0, 16'h0001, 16'h0000);  // No event
  endtask

  task automatic sc_updn();
    logic [DW-1:0] v;
    logic [DW-1:0] w;
    wr_reg(A_CCR0, 16'h0010);
    wr_reg(A_CCTL0, 16'h0080);
    wr_reg(A_CTL, 16'h0034);  // Up/down
    wait_eq(0);
    chk("out0", 16'h0001, {15'h0, ch_out[0]});  // Toggle
    @(posedge clk);
    rd_chk("flag0", A_CCTL0, 16'h0001, 16'h0001);  // At top
    rd_chk("ovf early", A_CTL, 16'h0001, 16'h0000);  // Not yet
    repeat (20) @(posedge clk);
    rd_chk("ovf", A_CTL, 16'h0001, 16'h0001);  // At zero
    wait_eq(0);
    @(posedge clk);
    wr_reg(A_CTL, 16'h0000);
    rd_reg(A_CNT, v);
    repeat (6) @(posedge clk);
    rd_chk("held", A_CNT, 16'hffff, v);  // Stopped
    wr_reg(A_CTL, 16'h0030);
    repeat (3) @(posedge clk);
    rd_reg(A_CNT, w);
    chk("dir kept", 16'h0001, {15'h0, w < v});  // Still down
    wr_reg(A_CTL, 16'h0004);
    rd_chk("cleared", A_CNT, 16'hffff, 16'h0000);  // Clear
    wr_reg(A_CTL, 16'h0030);
    rd_reg(A_CNT, v);
    rd_reg(A_CNT, w);
    chk("dir up", 16'h0001, {15'h0, w > v});  // Up again
  endtask

  // Channel 1 through all output modes, ch1 match before period match
  task automatic sc_modes();
    logic [7:0] e1;
    logic [7:0] e2;
    logic [7:0] st;
    e1 = 8'h5f;
    e2 = 8'hd3;
    st = 8'ha0;
    wr_reg(A_CCR0, 16'h0004);
    wr_reg(A_CCR0 + 4'h1, 16'h0002);
    for (int m = 0; m < 8; m++) begin
      wr_reg(A_CTL, 16'h0004);
      wr_reg(A_CCTL0 + 4'h1, {13'h0, st[m], 2'h0});  // Start level
      wr_reg(A_CCTL0 + 4'h1, {8'h00, m[2:0], 5'h04});
      wr_reg(A_CTL, 16'h0030);
      wait_eq(1);
      chk("out1 match", {15'h0, e1[m]}, {15'h0, ch_out[1]});
      wait_eq(0);
      chk("out1 top", {15'h0, e2[m]}, {15'h0, ch_out[1]});
      @(posedge clk);
    end
  endtask

  task automatic sc_cap();
    wr_reg(A_CTL, 16'h0000);
    wr_reg(A_CNT, 16'h0123);
    wr_reg(A_CCTL0 + 4'h2, 16'h4100);
    pins.drive(2, 1'b0, 1'b1);
    repeat (5) @(posedge clk);
    rd_chk("cap", A_CCTL0 + 4'h2, 16'h000b, 16'h0009);  // Rise
    wr_reg(A_CNT, 16'h0456);
    pins.drive(2, 1'b0, 1'b0);
    repeat (5) @(posedge clk);
    rd_chk("fall", A_CCTL0 + 4'h2, 16'h0002, 16'h0000);  // Ignored
    pins.drive(2, 1'b0, 1'b1);
    repeat (5) @(posedge clk);
    rd_chk("cov", A_CCTL0 + 4'h2, 16'h0002, 16'h0002);  // Unread
    rd_chk("ccr2", A_CCR0 + 4'h2, 16'hffff, 16'h0456);  // Count
    wr_reg(A_CCTL0 + 4'h2, 16'h4100);
    rd_chk("cov clr", A_CCTL0 + 4'h2, 16'h0003, 16'h0000);  // Write
    wr_reg(A_CNT, 16'h0789);
    wr_reg(A_CCTL0 + 4'h2, 16'hf100);
    wr_reg(A_CCTL0 + 4'h2, 16'he100);
    repeat (5) @(posedge clk);
    rd_chk("sw cap", A_CCR0 + 4'h2, 16'hffff, 16'h0789);  // Software
  endtask

  // Synchronised capture on input b waits for a timer tick
  task automatic sc_sync();
    wr_reg(A_CTL, 16'h0004);
    wr_reg(A_CNT, 16'h0abc);
    wr_reg(A_CCTL0 + 4'h2, 16'h5900);
    pins.drive(2, 1'b1, 1'b1);
    repeat (5) @(posedge clk);
    rd_chk("sync held", A_CCTL0 + 4'h2, 16'h0009, 16'h0008);
    wr_reg(A_CTL, 16'h00e0);
    repeat (10) @(posedge clk);
    rd_chk("sync flag", A_CCTL0 + 4'h2, 16'h0001, 16'h0001);
    rd_chk("sync ccr2", A_CCR0 + 4'h2, 16'hffff, 16'h0abc);
  endtask

  initial begin
    reset_n     = 1'b0;
    addr        = '0;
    wdata       = '0;
    wr          = 1'b0;
    rd          = 1'b0;
    mismatches  = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    sc_regs();
    sc_updn();
    sc_modes();
    sc_cap();
    sc_sync();
    print_verdict();
  end
endmodule
